// >>> design/monitor_calib_password_qt_regs.sv
// Calibration, password and quick-trip threshold register bank
`timescale 1ns/100ps

module monitor_calib_password_qt_regs #(
   parameter logic [15:0] GAIN_DEFAULT = 16'h8000,
   parameter logic [15:0] TEMP_OFF_DEFAULT = 16'h0000
) (
   input  wire logic                         clk,
   input  wire logic                         rstn,
   input  wire monitor_calib_pkg::reg_req_s  regReq,
   output      logic [7:0]                   regRdData,
   output      logic                         regRdValid,
   input  wire logic                         passEntryWr,
   input  wire logic [31:0]                  passEntry,
   input  wire logic                         bankRwPermit,
   input  wire logic                         bankReadPermit,
   input  wire logic                         level1PassWritePermit,
   input  wire logic                         quicktripEnableTx2,
   output      logic                         level1Access,
   output      logic                         level2Access,
   input  wire logic                         convDone,
   input  wire logic signed [15:0]           temperature,
   output      logic [7:0]                   temperatureIndex,
   output      logic                         lutRd,
   output      logic [7:0]                   lutAddr,
   input  wire logic [7:0]                   lutData,
   input  wire logic                         measStart,
   input  wire monitor_calib_pkg::meas_t     rawMeas,
   output      monitor_calib_pkg::meas_t     measResult,
   output      logic                         measResultValid,
   input  wire logic [15:0]                  biasMonitorTx2,
   input  wire logic [15:0]                  powerMonitorTx2,
   output      monitor_calib_pkg::qt_alarm_s alarm,
   output      logic [16:0]                  biasFsTx1,
   output      logic [16:0]                  powerFsTx1,
   output      logic [15:0]                  temperatureOffsetValue
);
   monitor_calib_pkg::state_s s_r;
   monitor_calib_pkg::state_s s_nxt;
   monitor_calib_pkg::state_s resetVal;

   logic [7:0]  reqIdx;
   logic        inBank;
   logic        isPass1;
   logic        isPass2;
   logic        isThr;
   logic        readOk;
   logic        writeOk;
   logic [7:0]  wrMask;
   logic [2:0]  lutSlot;
   logic [16:0] hbThr;
   logic [16:0] phThr;
   logic [16:0] plThr;
   logic signed [15:0] tDeg;
   logic [7:0]  newIndex;
   logic [15:0] chResult [monitor_calib_pkg::MEAS_CH];
   logic [2:0]  chShift  [monitor_calib_pkg::MEAS_CH];
   logic [7:0]  shiftTx2, shiftTx1, rangeTx2, rangeTx1;

   function automatic logic [7:0] byteAt(
      input logic [monitor_calib_pkg::BANK_BYTES-1:0][7:0] b,
      input logic [7:0] a);
      logic [7:0] i;
      i = a - monitor_calib_pkg::BANK_BASE;
      byteAt = b[i[5:0]];
   endfunction

   function automatic logic [15:0] wordAt(
      input logic [monitor_calib_pkg::BANK_BYTES-1:0][7:0] b,
      input logic [7:0] a);
      wordAt = {byteAt(b, a), byteAt(b, a + 8'h01)};
   endfunction

   function automatic logic [31:0] longAt(
      input logic [monitor_calib_pkg::BANK_BYTES-1:0][7:0] b,
      input logic [7:0] a);
      longAt = {wordAt(b, a), wordAt(b, a + 8'h02)};
   endfunction

   // Reserved ranging and shift bits stay zero because they are never stored
   function automatic logic [7:0] maskOf(input logic [7:0] a);
      if (a >= monitor_calib_pkg::ADDR_RANGE_TX2
          && a <= monitor_calib_pkg::ADDR_SHIFT_TX1) begin
         maskOf = monitor_calib_pkg::RANGE_MASK;
      end else if ((a >= monitor_calib_pkg::ADDR_SUPPLY_GAIN
                    && a <= monitor_calib_pkg::ADDR_SUPPLY_GAIN + 8'h01)
                   || (a >= monitor_calib_pkg::ADDR_BGAIN_TX2
                       && a <= monitor_calib_pkg::ADDR_SUPPLY_OFF + 8'h01)
                   || (a >= monitor_calib_pkg::ADDR_BOFF_TX2
                       && a <= monitor_calib_pkg::ADDR_PASS2 + 8'h03)
                   || (a >= monitor_calib_pkg::ADDR_HB_THR_TX2
                       && a <= monitor_calib_pkg::ADDR_PL_THR_TX2)) begin
         maskOf = monitor_calib_pkg::FULL_MASK;
      end else begin
         maskOf = monitor_calib_pkg::ZERO_BYTE;
      end
   endfunction

   function automatic logic [16:0] scaleThr(input logic [7:0] dac,
                                            input logic [2:0] code);
      logic [32:0] p;
      p = {dac, 8'h00} * monitor_calib_pkg::FS_FRAC[code];
      scaleThr = p[32:16];
   endfunction

   always_comb begin
      resetVal = '0;
      resetVal.entered = monitor_calib_pkg::PASS_RESET;
      resetVal.temperature_index = monitor_calib_pkg::INDEX_MIN;
      resetVal.st = monitor_calib_pkg::RELOAD_IDLE;
      for (int c = 0; c < monitor_calib_pkg::MEAS_CH; c++) begin
         resetVal.bank[6'(monitor_calib_pkg::GAIN_ADDR[c]
                         - monitor_calib_pkg::BANK_BASE)] = GAIN_DEFAULT[15:8];
         resetVal.bank[6'(monitor_calib_pkg::GAIN_ADDR[c]
                         - monitor_calib_pkg::BANK_BASE + 8'h01)] =
            GAIN_DEFAULT[7:0];
      end
      resetVal.bank[6'(monitor_calib_pkg::ADDR_TEMP_OFFSET
                      - monitor_calib_pkg::BANK_BASE)] = TEMP_OFF_DEFAULT[15:8];
      resetVal.bank[6'(monitor_calib_pkg::ADDR_TEMP_OFFSET
                      - monitor_calib_pkg::BANK_BASE + 8'h01)] =
         TEMP_OFF_DEFAULT[7:0];
      for (int k = 0; k < 8; k++) begin
         resetVal.bank[6'(monitor_calib_pkg::ADDR_PASS1
                         - monitor_calib_pkg::BANK_BASE) + 6'(k)] =
            monitor_calib_pkg::FULL_MASK;
      end
   end

   assign level1Access = s_r.entered
                         == longAt(s_r.bank, monitor_calib_pkg::ADDR_PASS1);
   assign level2Access = s_r.entered
                         == longAt(s_r.bank, monitor_calib_pkg::ADDR_PASS2);

   assign reqIdx = regReq.addr - monitor_calib_pkg::BANK_BASE;
   assign inBank = regReq.addr >= monitor_calib_pkg::BANK_BASE
                   && regReq.addr <= monitor_calib_pkg::ADDR_PL_THR_TX2;
   assign isPass1 = regReq.addr >= monitor_calib_pkg::ADDR_PASS1
                    && regReq.addr < monitor_calib_pkg::ADDR_PASS2;
   assign isPass2 = regReq.addr >= monitor_calib_pkg::ADDR_PASS2
                    && regReq.addr <= monitor_calib_pkg::ADDR_PASS2 + 8'h03;
   assign isThr = regReq.addr >= monitor_calib_pkg::ADDR_HB_THR_TX2
                  && regReq.addr <= monitor_calib_pkg::ADDR_PL_THR_TX2;
   assign wrMask = maskOf(regReq.addr);

   assign readOk = level2Access
                   || (level1Access && (bankRwPermit || bankReadPermit));

   always_comb begin
      if (isPass2) begin
         writeOk = level2Access;
      end else if (isPass1) begin
         writeOk = level2Access
                   || (level1Access && level1PassWritePermit);
      end else if (isThr) begin
         writeOk = !quicktripEnableTx2
                   && (level2Access || (level1Access && bankRwPermit));
      end else begin
         writeOk = level2Access || (level1Access && bankRwPermit);
      end
   end

   // Index from whole degrees; fraction dropped so -41.5 C still clamps
   assign tDeg = temperature >>> monitor_calib_pkg::TEMP_FRAC_BITS;
   always_comb begin
      logic signed [15:0] half;
      half = (tDeg + monitor_calib_pkg::TEMP_BIAS) >>> 1;
      if (tDeg < monitor_calib_pkg::TEMP_LOW) begin
         newIndex = monitor_calib_pkg::INDEX_MIN;
      end else if (tDeg > monitor_calib_pkg::TEMP_HIGH) begin
         newIndex = monitor_calib_pkg::INDEX_MAX;
      end else begin
         newIndex = half[7:0] + monitor_calib_pkg::INDEX_MIN;
      end
   end

   // Eight-entry table slot: 2-degree index folded onto 16-degree bands
   always_comb begin
      if (s_r.temperature_index[6]) begin
         lutSlot = 3'h7;
      end else if (s_r.temperature_index[5:3] <= 3'h1) begin
         lutSlot = 3'h0;
      end else begin
         lutSlot = s_r.temperature_index[5:3] - 3'h1;
      end
   end

   always_comb begin
      lutRd = 1'b1;
      case (s_r.st)
         monitor_calib_pkg::RELOAD_HB:
            lutAddr = monitor_calib_pkg::LUT_HB_BASE + {5'h00, lutSlot};
         monitor_calib_pkg::RELOAD_PH:
            lutAddr = monitor_calib_pkg::LUT_PH_BASE + {5'h00, lutSlot};
         monitor_calib_pkg::RELOAD_PL:
            lutAddr = monitor_calib_pkg::LUT_PL_BASE + {5'h00, lutSlot};
         default: begin
            lutAddr = monitor_calib_pkg::ZERO_BYTE;
            lutRd = 1'b0;
         end
      endcase
   end

   // Measurement path: gain, offset, clamp, then right shift on the four Tx channels; supply is never shifted
   assign shiftTx2 = byteAt(s_r.bank, monitor_calib_pkg::ADDR_SHIFT_TX2);
   assign shiftTx1 = byteAt(s_r.bank, monitor_calib_pkg::ADDR_SHIFT_TX1);
   assign chShift[0] = 3'h0;
   assign chShift[1] = shiftTx2[monitor_calib_pkg::BIAS_LSB +: 3];
   assign chShift[2] = shiftTx2[monitor_calib_pkg::POWER_LSB +: 3];
   assign chShift[3] = shiftTx1[monitor_calib_pkg::BIAS_LSB +: 3];
   assign chShift[4] = shiftTx1[monitor_calib_pkg::POWER_LSB +: 3];

   generate
      for (genvar c = 0; c < monitor_calib_pkg::MEAS_CH; c++) begin : g_ch
         logic [31:0]        prod;
         logic [15:0]        scaled;
         logic signed [18:0] sum;
         logic signed [17:0] offs;
         logic [15:0]        clamped;
         // Gain word is unsigned with 8000h as unity
         assign prod = rawMeas[c]
                       * wordAt(s_r.bank, monitor_calib_pkg::GAIN_ADDR[c]);
         assign scaled = prod[31] ? 16'hFFFF : prod[30:15];
         assign offs = {wordAt(s_r.bank, monitor_calib_pkg::OFF_ADDR[c]),
                        2'b00};
         assign sum = $signed({3'b000, scaled}) + 19'(offs);
         assign clamped = sum < 0 ? 16'h0000
                        : (sum > 19'sh0FFFF ? 16'hFFFF : sum[15:0]);
         assign chResult[c] = clamped >> chShift[c];
      end
   endgenerate

   assign rangeTx2 = byteAt(s_r.bank, monitor_calib_pkg::ADDR_RANGE_TX2);
   assign hbThr = scaleThr(
      byteAt(s_r.bank, monitor_calib_pkg::ADDR_HB_THR_TX2),
      rangeTx2[monitor_calib_pkg::BIAS_LSB +: 3]);
   assign phThr = scaleThr(
      byteAt(s_r.bank, monitor_calib_pkg::ADDR_PH_THR_TX2),
      rangeTx2[monitor_calib_pkg::POWER_LSB +: 3]);
   assign plThr = scaleThr(
      byteAt(s_r.bank, monitor_calib_pkg::ADDR_PL_THR_TX2),
      rangeTx2[monitor_calib_pkg::POWER_LSB +: 3]);

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdValid = regReq.rd;
      s_nxt.measValid = measStart;
      if (passEntryWr) begin
         s_nxt.entered = passEntry;
      end
      if (regReq.rd) begin
         // Passwords and refused reads both answer zero
         if (inBank && readOk && !isPass1 && !isPass2) begin
            s_nxt.rdData = byteAt(s_r.bank, regReq.addr) & wrMask;
         end else begin
            s_nxt.rdData = monitor_calib_pkg::ZERO_BYTE;
         end
      end
      if (regReq.wr && inBank && writeOk) begin
         s_nxt.bank[reqIdx[5:0]] = (regReq.data & wrMask)
            | (s_r.bank[reqIdx[5:0]] & ~wrMask);
      end
      if (measStart) begin
         for (int c = 0; c < monitor_calib_pkg::MEAS_CH; c++) begin
            s_nxt.meas[c] = chResult[c];
         end
      end
      s_nxt.alarm.highBias = {1'b0, biasMonitorTx2} > hbThr;
      s_nxt.alarm.powerHigh = {1'b0, powerMonitorTx2} > phThr;
      s_nxt.alarm.powerLow = {1'b0, powerMonitorTx2} < plThr;
      // Table reload wins over a host write to the same threshold
      case (s_r.st)
         monitor_calib_pkg::RELOAD_IDLE: begin
            if (convDone) begin
               s_nxt.temperature_index = newIndex;
               s_nxt.st = monitor_calib_pkg::RELOAD_HB;
            end
         end
         monitor_calib_pkg::RELOAD_HB: begin
            s_nxt.bank[6'(monitor_calib_pkg::ADDR_HB_THR_TX2
                         - monitor_calib_pkg::BANK_BASE)] = lutData;
            s_nxt.st = monitor_calib_pkg::RELOAD_PH;
         end
         monitor_calib_pkg::RELOAD_PH: begin
            s_nxt.bank[6'(monitor_calib_pkg::ADDR_PH_THR_TX2
                         - monitor_calib_pkg::BANK_BASE)] = lutData;
            s_nxt.st = monitor_calib_pkg::RELOAD_PL;
         end
         monitor_calib_pkg::RELOAD_PL: begin
            s_nxt.bank[6'(monitor_calib_pkg::ADDR_PL_THR_TX2
                         - monitor_calib_pkg::BANK_BASE)] = lutData;
            s_nxt.st = monitor_calib_pkg::RELOAD_IDLE;
         end
         default: s_nxt.st = monitor_calib_pkg::RELOAD_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= resetVal;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regRdData = s_r.rdData;
   assign regRdValid = s_r.rdValid;
   assign temperatureIndex = s_r.temperature_index;
   assign measResult = s_r.meas;
   assign measResultValid = s_r.measValid;
   assign alarm = s_r.alarm;
   assign rangeTx1 = byteAt(s_r.bank, monitor_calib_pkg::ADDR_RANGE_TX1);
   assign biasFsTx1 = monitor_calib_pkg::FS_FRAC[
      rangeTx1[monitor_calib_pkg::BIAS_LSB +: 3]];
   assign powerFsTx1 = monitor_calib_pkg::FS_FRAC[
      rangeTx1[monitor_calib_pkg::POWER_LSB +: 3]];
   // Host stores the value XORed; undo it here for the temperature path
   assign temperatureOffsetValue =
      wordAt(s_r.bank, monitor_calib_pkg::ADDR_TEMP_OFFSET)
      ^ monitor_calib_pkg::TEMP_OFFSET_XOR;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   pass_read_zero_a: assert property (
      regReq.rd && (isPass1 || isPass2) |=> regRdData == 8'h00)
      else $error("password read not zero");
   pass2_guard_a: assert property (
      regReq.wr && isPass2 && !level2Access
      |-> s_nxt.bank[reqIdx[5:0]] == s_r.bank[reqIdx[5:0]])
      else $error("password two written without level two");
   pass1_guard_a: assert property (
      regReq.wr && isPass1 && !level2Access
      && !(level1Access && level1PassWritePermit)
      |-> s_nxt.bank[reqIdx[5:0]] == s_r.bank[reqIdx[5:0]])
      else $error("password one written without permission");
   thr_lock_a: assert property (
      regReq.wr && isThr && quicktripEnableTx2
      && s_r.st == monitor_calib_pkg::RELOAD_IDLE
      |-> s_nxt.bank[reqIdx[5:0]] == s_r.bank[reqIdx[5:0]])
      else $error("threshold written while quick trip enabled");
   reset_access_a: assert property (
      !$past(rstn) |-> level1Access && level2Access)
      else $error("default passwords do not grant access");
   reload_seq_a: assert property (
      convDone && s_r.st == monitor_calib_pkg::RELOAD_IDLE
      |=> lutRd ##1 lutRd ##1 lutRd ##1 !lutRd)
      else $error("threshold reload sequence wrong");
   reload_addr_a: assert property (
      lutRd |-> lutAddr >= 8'hE0 && lutAddr <= 8'hF7)
      else $error("table address out of threshold area");
   index_clamp_a: assert property (
      temperatureIndex >= 8'h80 && temperatureIndex <= 8'hC7)
      else $error("temperature index outside clamp");
   range_reserved_a: assert property (
      regReq.rd && regReq.addr == monitor_calib_pkg::ADDR_RANGE_TX2
      |=> regRdData[7] == 1'b0 && regRdData[3] == 1'b0)
      else $error("reserved ranging bits read nonzero");
   read_refused_a: assert property (
      regReq.rd && !level2Access
      && !(level1Access && (bankRwPermit || bankReadPermit))
      |=> regRdData == 8'h00 ##1 1'b1)
      else $error("read granted without permission");
   bias_alarm_a: assert property (
      1'b1 |=> alarm.highBias
               == ({1'b0, $past(biasMonitorTx2)} > $past(hbThr)))
      else $error("high bias alarm mismatch");
endmodule

// >>> design/monitor_calib_pkg.sv
// Constants, types and register map for the calibration and quick-trip bank
package monitor_calib_pkg;
   localparam logic [7:0] ADDR_RANGE_TX2    = 8'h8C;
   localparam logic [7:0] ADDR_RANGE_TX1    = 8'h8D;
   localparam logic [7:0] ADDR_SHIFT_TX2    = 8'h8E;
   localparam logic [7:0] ADDR_SHIFT_TX1    = 8'h8F;
   localparam logic [7:0] ADDR_SUPPLY_GAIN  = 8'h92;
   localparam logic [7:0] ADDR_BGAIN_TX2    = 8'h98;
   localparam logic [7:0] ADDR_PGAIN_TX2    = 8'h9A;
   localparam logic [7:0] ADDR_BGAIN_TX1    = 8'h9C;
   localparam logic [7:0] ADDR_PGAIN_TX1    = 8'h9E;
   localparam logic [7:0] ADDR_TEMP_OFFSET  = 8'hA0;
   localparam logic [7:0] ADDR_SUPPLY_OFF   = 8'hA2;
   localparam logic [7:0] ADDR_BOFF_TX2     = 8'hA8;
   localparam logic [7:0] ADDR_POFF_TX2     = 8'hAA;
   localparam logic [7:0] ADDR_BOFF_TX1     = 8'hAC;
   localparam logic [7:0] ADDR_POFF_TX1     = 8'hAE;
   localparam logic [7:0] ADDR_PASS1        = 8'hB0;
   localparam logic [7:0] ADDR_PASS2        = 8'hB4;
   localparam logic [7:0] ADDR_HB_THR_TX2   = 8'hB9;
   localparam logic [7:0] ADDR_PH_THR_TX2   = 8'hBA;
   localparam logic [7:0] ADDR_PL_THR_TX2   = 8'hBB;
   localparam logic [7:0] BANK_BASE         = 8'h8C;
   localparam int         BANK_BYTES        = 48;
   localparam logic [7:0] RANGE_MASK        = 8'h77;
   localparam logic [7:0] FULL_MASK         = 8'hFF;
   localparam logic [7:0] ZERO_BYTE         = 8'h00;
   localparam int         BIAS_LSB          = 4;
   localparam int         POWER_LSB         = 0;
   localparam logic [31:0] PASS_RESET       = 32'hFFFF_FFFF;
   localparam logic [15:0] TEMP_OFFSET_XOR  = 16'hBB40;
   localparam logic [7:0] LUT_HB_BASE       = 8'hE0;
   localparam logic [7:0] LUT_PH_BASE       = 8'hE8;
   localparam logic [7:0] LUT_PL_BASE       = 8'hF0;
   localparam logic [7:0] INDEX_MIN         = 8'h80;
   localparam logic [7:0] INDEX_MAX         = 8'hC7;
   localparam logic signed [15:0] TEMP_LOW  = -16'sd40;
   localparam logic signed [15:0] TEMP_HIGH = 16'sd102;
   localparam logic signed [15:0] TEMP_BIAS = 16'sd40;
   localparam int         TEMP_FRAC_BITS    = 8;
   localparam int         MEAS_CH           = 5;
   // Full-scale fraction per ranging code, 1.0 = 17'h10000
   localparam logic [16:0] FS_FRAC [8] = '{17'h10000, 17'h0CCE1,
      17'h0AAC6, 17'h0802E, 17'h0669B, 17'h05587, 17'h04958, 17'h04034};
   localparam logic [7:0] GAIN_ADDR [MEAS_CH] = '{ADDR_SUPPLY_GAIN,
      ADDR_BGAIN_TX2, ADDR_PGAIN_TX2, ADDR_BGAIN_TX1, ADDR_PGAIN_TX1};
   localparam logic [7:0] OFF_ADDR [MEAS_CH] = '{ADDR_SUPPLY_OFF,
      ADDR_BOFF_TX2, ADDR_POFF_TX2, ADDR_BOFF_TX1, ADDR_POFF_TX1};

   typedef enum logic [1:0] {
      RELOAD_IDLE = 2'b00,
      RELOAD_HB   = 2'b01,
      RELOAD_PH   = 2'b10,
      RELOAD_PL   = 2'b11
   } reload_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_req_s;

   typedef struct packed {
      logic highBias;
      logic powerHigh;
      logic powerLow;
   } qt_alarm_s;

   typedef logic [MEAS_CH-1:0][15:0] meas_t;

   typedef struct packed {
      logic [BANK_BYTES-1:0][7:0] bank;
      logic [31:0]                entered;
      logic [7:0]                 temperature_index;
      reload_e                    st;
      logic [7:0]                 rdData;
      logic                       rdValid;
      meas_t                      meas;
      logic                       measValid;
      qt_alarm_s                  alarm;
   } state_s;
endpackage

// >>> verif/lut_model.sv
// Lookup table memory model answering the threshold reload port
`timescale 1ns/100ps
module lut_model (
   input  wire logic       lutRd,
   input  wire logic [7:0] lutAddr,
   output      logic [7:0] lutData
);
   // Nibble swap gives each entry its own byte; idle bus shows a wrong byte
   assign lutData = lutRd ? ({lutAddr[3:0], lutAddr[7:4]} ^ 8'hA5) : ~lutAddr;
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the calibration and quick-trip bank
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
   logic                         clk, rstn, pWr, convDone, measStart;
   logic                         rwOk, rdOk, qtEn, rdValid, l1, l2, lutRd;
   logic                         measValid, wpOk;
   monitor_calib_pkg::reg_req_s  req;
   monitor_calib_pkg::qt_alarm_s alarm;
   monitor_calib_pkg::meas_t     raw, res;
   logic [31:0]                  pEntry;
   logic [15:0]                  temp, biasMon, powMon, tOff, t;
   logic [16:0]                  biasFs, powFs;
   logic [7:0]                   rdData, tIdx, lutAddr, lutData, r;
   integer                       seed = 32'h656C, cyc = 0;
   integer                       error_cnt = 0, compares = 0;

   monitor_calib_password_qt_regs DUT (.clk(clk), .rstn(rstn), .regReq(req),
      .regRdData(rdData), .regRdValid(rdValid), .passEntryWr(pWr),
      .passEntry(pEntry), .bankRwPermit(rwOk), .bankReadPermit(rdOk),
      .level1PassWritePermit(wpOk), .quicktripEnableTx2(qtEn),
      .level1Access(l1), .level2Access(l2), .convDone(convDone),
      .temperature(temp), .temperatureIndex(tIdx), .lutRd(lutRd),
      .lutAddr(lutAddr), .lutData(lutData), .measStart(measStart),
      .rawMeas(raw), .measResult(res), .measResultValid(measValid),
      .biasMonitorTx2(biasMon), .powerMonitorTx2(powMon), .alarm(alarm),
      .biasFsTx1(biasFs), .powerFsTx1(powFs), .temperatureOffsetValue(tOff));
   lut_model LUT (.lutRd(lutRd), .lutAddr(lutAddr), .lutData(lutData));

   function automatic logic [7:0] lut(input logic [7:0] a);
      return {a[3:0], a[7:4]} ^ 8'hA5;
   endfunction
   function automatic logic [7:0] slot(input logic [7:0] i);
      if (i[6]) return 8'h07;
      return (i[5:3] <= 3'h1) ? 8'h00 : 8'(i[5:3] - 3'h1);
   endfunction
   function automatic logic [15:0] thr(input logic [7:0] d);
      return 16'((33'({d, 8'h00}) * 33'(monitor_calib_pkg::FS_FRAC[7])) >> 16);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) req = '{1'b1, 1'b0, a, d};
      @(negedge clk) req = '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk) req = '0;
      `CHK("rdValid", 1'b1, rdValid)
      `CHK("rdData", e, rdData)
   endtask
   task automatic enter(input logic [31:0] p);
      @(negedge clk) begin pWr = 1'b1; pEntry = p; end
      @(negedge clk) pWr = 1'b0;
   endtask
   // Reload spacing of four cycles is met since the next pulse follows c3
   task automatic reload(input logic [15:0] tp, input logic [7:0] idx);
      logic [7:0] a;
      a = 8'hE0 + slot(idx);
      @(negedge clk) begin convDone = 1'b1; temp = tp; end
      for (int k = 0; k < 3; k++) begin
         @(negedge clk) convDone = 1'b0;
         `CHK("lutAddr", 8'(a + 8 * k), lutAddr)
      end
      `CHK("tIdx", idx, tIdx)
   endtask
   task automatic end_of_test;
      $display("Checks %0d, errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      {rstn, pWr, convDone, measStart, rwOk, rdOk, qtEn, wpOk} = '0;
      {req, raw, temp, biasMon, powMon} = '0;
      pEntry = '1;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      `CHK("l1", 1'b1, l1)
      `CHK("l2", 1'b1, l2)
      rd(8'hB0, 8'h00);
      rd(8'hBB, 8'h00);
      wr(8'h8C, 8'hFF);
      rd(8'h8C, 8'h77);
      r = 8'($random(seed));
      wr(8'h8D, r);
      `CHK("biasFs", monitor_calib_pkg::FS_FRAC[r[6:4]], biasFs)
      `CHK("powFs", monitor_calib_pkg::FS_FRAC[r[2:0]], powFs)
      t = 16'($random(seed));
      wr(8'hA0, t[15:8] ^ 8'hBB);
      wr(8'hA1, t[7:0] ^ 8'h40);
      `CHK("tOff", t, tOff)
      repeat (4) begin
         r = 8'($random(seed));
         wr(8'h8E, r);
         wr(8'h8F, ~r);
         @(negedge clk) measStart = 1'b1;
         raw = 80'({$random(seed), $random(seed), $random(seed)});
         @(negedge clk) measStart = 1'b0;
         `CHK("valid", 1'b1, measValid)
         `CHK("supply", raw[0], res[0])
         `CHK("bias", raw[1] >> r[6:4], res[1])
         `CHK("power", raw[2] >> r[2:0], res[2])
         `CHK("bias1", raw[3] >> ~r[6:4], res[3])
         `CHK("power1", raw[4] >> ~r[2:0], res[4])
      end
      // Offset of minus one step takes four off the supply reading
      wr(8'hA2, 8'hFF);
      wr(8'hA3, 8'hFF);
      @(negedge clk) begin measStart = 1'b1; raw[0] = 16'h0100; end
      @(negedge clk) measStart = 1'b0;
      `CHK("offset", 16'h00FC, res[0])
      reload(16'h1400, 8'h9E);
      reload(16'hCE00, 8'h80);
      rd(8'hBA, lut(8'hE8));
      biasMon = thr(lut(8'hE0)) + 16'h0001;
      powMon = thr(lut(8'hE8)) + 16'h0001;
      repeat (2) @(negedge clk);
      `CHK("hb", 1'b1, alarm.highBias)
      `CHK("ph", 1'b1, alarm.powerHigh)
      `CHK("pl", powMon < thr(lut(8'hF0)), alarm.powerLow)
      wr(8'hB7, 8'h00);
      `CHK("l2", 1'b0, l2)
      rd(8'h8C, 8'h00);
      rdOk = 1'b1;
      rd(8'h8C, 8'h77);
      wr(8'h8C, 8'h00);
      rd(8'h8C, 8'h77);
      enter(32'hFFFF_FF00);
      `CHK("l1", 1'b0, l1)
      `CHK("l2", 1'b1, l2)
      qtEn = 1'b1;
      wr(8'hB9, 8'h55);
      rd(8'hB9, lut(8'hE0));
      wr(8'hB3, 8'h00);
      `CHK("l1", 1'b1, l1)
      wr(8'hB2, 8'h00);
      enter(32'hFFFF_0000);
      `CHK("l2", 1'b0, l2)
      wr(8'hB3, 8'h11);
      wr(8'hB7, 8'h33);
      `CHK("l1", 1'b1, l1)
      wpOk = 1'b1;
      wr(8'hB3, 8'h11);
      `CHK("l1", 1'b0, l1)
      enter(32'hFFFF_FF00);
      `CHK("l2", 1'b1, l2)
      end_of_test();
   end
endmodule
